// >>> serial_bus_master_receiver_ctrl.sv
// module: two-wire bus master with control/status/data registers
`timescale 1ns/1ps
`default_nettype none

module serial_bus_master_receiver_ctrl
  import sbus_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic [1:0] host_link_select_i,
  input wire logic bus_irq_enable_i,
  input wire logic [7:0] timer_reload_i,
  output logic irq_o,
  input wire logic bus_clock_pin_i,
  output logic bus_clock_pin_o,
  output logic bus_clock_pin_oe_o,
  input wire logic bus_data_pin_i,
  output logic bus_data_pin_o,
  output logic bus_data_pin_oe_o
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  sbus_state_e state, next_state;
  logic [7:0] ctrl, next_ctrl, status, next_status;
  logic [7:0] data, next_data, own_addr, next_own_addr, next_rdata;
  logic [11:0] cnt, next_cnt;
  logic [3:0] bitcnt, next_bitcnt;
  logic master, next_master, rx, next_rx, addr_ph, next_addr_ph;
  logic rep, next_rep, busy, next_busy, si_set;
  logic scl_drv, sda_drv, next_irq;
  logic scl_s1, scl_s2, sda_s1, sda_s2, sda_q;
  logic [1:0] scl_oe_hist;
  logic en, ctrl_wr, start_seen, stop_seen, slave_halt;
  logic stall, tick, reload, acked;

  // half bit period in cpu clocks for the selected rate
  function automatic logic [11:0] half_of(input logic [2:0] sel,
                                          input logic [7:0] rl);
    case (sel)
      3'd0: half_of = 12'(DIV0 / 2);
      3'd1: half_of = 12'(DIV1 / 2);
      3'd2: half_of = 12'(DIV2 / 2);
      3'd3: half_of = 12'(DIV3 / 2);
      3'd4: half_of = 12'(DIV4 / 2);
      3'd5: half_of = 12'(DIV5 / 2);
      3'd6: half_of = 12'(DIV6 / 2);
      default: half_of = 12'((TIMER_BASE - int'(rl)) * TIMER_MULT / 2);
    endcase
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers and bus condition detection
  // ---------------------------------------------------------------
  // pins are asynchronous; the first stage feeds nothing but the second stage
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_q <= 1'b1;
      scl_oe_hist <= 2'b00;
    end else begin
      scl_s1 <= bus_clock_pin_i;
      scl_s2 <= scl_s1;
      sda_s1 <= bus_data_pin_i;
      sda_s2 <= sda_s1;
      sda_q <= sda_s2;
      // our own clock drive, delayed to line up with the synchroniser
      scl_oe_hist <= {scl_oe_hist[0], bus_clock_pin_oe_o};
    end
  end

  // enable needs the link select as well; pins are ignored when off
  assign en = ctrl[ENABLE_BIT] && (host_link_select_i == LINK_SEL_BUS);
  assign start_seen = en && scl_s2 && sda_q && !sda_s2;
  assign stop_seen = en && scl_s2 && !sda_q && sda_s2;
  assign slave_halt = en && ctrl[HALT_BIT] && !master;
  assign ctrl_wr = sfr_wr_i && (sfr_addr_i == CTRL_ADDR);

  // a slave may hold the clock low in any high phase we released; the
  // pin is only trusted once our release has passed the synchroniser,
  // otherwise every high phase would grow by two clocks
  assign stall = !scl_s2 && (scl_oe_hist == 2'b00) &&
                 (state == s_bit_hi || state == s_ack_hi ||
                  state == s_rs_hi || state == s_stop_hi);
  assign tick = (cnt == 12'h000) && !stall;
  assign reload = tick || state == s_idle || state == s_hold ||
                  (state == s_wait && busy);
  assign acked = !sda_s2;

  // ---------------------------------------------------------------
  // bit timing counter
  // ---------------------------------------------------------------
  always_comb begin
    if (reload) begin
      next_cnt = half_of({ctrl[RATE_HI_BIT], ctrl[RATE_LO_MSB:0]},
                         timer_reload_i) - 12'h001;
    end else if (stall) begin
      next_cnt = cnt;
    end else begin
      next_cnt = cnt - 12'h001;
    end
  end

  // ---------------------------------------------------------------
  // bus sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_status = status;
    next_bitcnt = bitcnt;
    next_master = master;
    next_rx = rx;
    next_addr_ph = addr_ph;
    next_rep = rep;
    si_set = 1'b0;
    next_data = data;
    if (sfr_wr_i && sfr_addr_i == DATA_ADDR) begin
      next_data = sfr_wdata_i;
    end
    unique case (state)
      s_idle: begin
        if (ctrl[BEGIN_BIT] && !(ctrl[HALT_BIT] && !slave_halt)) begin
          next_state = busy ? s_wait : s_start;
          next_rep = 1'b0;
        end
      end
      s_wait: begin
        if (!ctrl[BEGIN_BIT]) begin
          next_state = s_idle;
        end else if (tick) begin
          next_state = s_start;
        end
      end
      s_start: begin
        if (tick) begin
          next_state = s_hold;
          next_status = rep ? ST_RSTART : ST_START;
          si_set = 1'b1;
          next_master = 1'b1;
          next_addr_ph = 1'b1;
          next_rx = 1'b0;
        end
      end
      s_hold: begin
        // clock stays low until firmware clears the event flag
        if (!ctrl[EVENT_BIT]) begin
          next_bitcnt = 4'h0;
          if (ctrl[HALT_BIT]) begin
            next_state = s_stop_lo;
          end else if (ctrl[BEGIN_BIT]) begin
            next_state = s_rs_lo;
          end else begin
            next_state = s_bit_lo;
          end
        end
      end
      s_bit_lo: begin
        if (tick) begin
          next_state = s_bit_hi;
        end
      end
      s_bit_hi: begin
        if (tick) begin
          // one register shifts both ways: sent bits read back
          next_data = {data[6:0], sda_s2};
          next_bitcnt = bitcnt + 4'h1;
          if (!rx && data[7] && !sda_s2) begin
            next_state = s_idle; // lost arbitration: let go
            next_status = ST_ARB_LOST;
            si_set = 1'b1;
            next_master = 1'b0;
          end else if (bitcnt == 4'(BITS_PER_BYTE - 1)) begin
            next_state = s_ack_lo;
          end else begin
            next_state = s_bit_lo;
          end
        end
      end
      s_ack_lo: begin
        if (tick) begin
          next_state = s_ack_hi;
        end
      end
      s_ack_hi: begin
        if (tick) begin
          next_state = s_hold;
          si_set = 1'b1;
          next_addr_ph = 1'b0;
          if (addr_ph) begin
            next_rx = data[0];
            if (data[0]) begin
              next_status = acked ? ST_AR_ACK : ST_AR_NACK;
            end else begin
              next_status = acked ? ST_AW_ACK : ST_AW_NACK;
            end
          end else if (rx) begin
            next_status = acked ? ST_DR_ACK : ST_DR_NACK;
          end else begin
            next_status = acked ? ST_DW_ACK : ST_DW_NACK;
          end
        end
      end
      s_rs_lo: begin
        if (tick) begin
          next_state = s_rs_hi;
        end
      end
      s_rs_hi: begin
        if (tick) begin
          next_state = s_start;
          next_rep = 1'b1;
        end
      end
      s_stop_lo: begin
        if (tick) begin
          next_state = s_stop_hi;
        end
      end
      s_stop_hi: begin
        if (tick) begin
          next_state = s_stop_end;
        end
      end
      s_stop_end: begin
        // the half period here spaces a following start
        if (tick) begin
          next_state = s_idle;
          next_master = 1'b0;
          next_status = ST_IDLE;
        end
      end
    endcase
    if (!en) begin
      next_state = s_idle;
      next_master = 1'b0;
      next_rx = 1'b0;
      next_status = ST_IDLE;
      si_set = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // pin drive, registers, bus busy and read data
  // ---------------------------------------------------------------
  always_comb begin
    // open drain: enable pulls the line low, release lets it float
    scl_drv = next_state inside {s_hold, s_bit_lo, s_ack_lo, s_rs_lo,
                                 s_stop_lo};
    // data follows the clock by one cpu clock, so it never moves in the
    // same instant as a falling clock and a slave cannot see a false start
    unique case (state)
      s_start, s_stop_lo, s_stop_hi: sda_drv = 1'b1;
      s_bit_lo, s_bit_hi: sda_drv = !rx && !data[7];
      s_ack_lo, s_ack_hi: sda_drv = rx && !addr_ph && ctrl[ACK_BIT];
      s_hold: sda_drv = bus_data_pin_oe_o;
      default: sda_drv = 1'b0; // line left released
    endcase
    if (!en) begin
      sda_drv = 1'b0;
    end
    next_ctrl = ctrl_wr ? sfr_wdata_i : ctrl;
    if (si_set) begin
      next_ctrl[EVENT_BIT] = 1'b1;
    end
    if (!ctrl[ENABLE_BIT] || stop_seen || slave_halt) begin
      next_ctrl[HALT_BIT] = 1'b0;
    end
    next_busy = busy;
    if (!en || stop_seen || slave_halt) begin
      next_busy = 1'b0;
    end else if (start_seen) begin
      next_busy = 1'b1;
    end
    next_own_addr = own_addr;
    if (sfr_wr_i && sfr_addr_i == OWN_ADDR) begin
      next_own_addr = sfr_wdata_i;
    end
    unique case (sfr_addr_i)
      CTRL_ADDR: next_rdata = ctrl;
      STAT_ADDR: next_rdata = status;
      DATA_ADDR: next_rdata = data;
      OWN_ADDR: next_rdata = own_addr;
      default: next_rdata = UNMAPPED_READ;
    endcase
    next_irq = ctrl[EVENT_BIT] && bus_irq_enable_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= s_idle;
      ctrl <= CTRL_RESET;
      status <= ST_IDLE;
      data <= DATA_RESET;
      own_addr <= OWN_RESET;
      cnt <= 12'h000;
      bitcnt <= 4'h0;
      master <= 1'b0;
      rx <= 1'b0;
      addr_ph <= 1'b0;
      rep <= 1'b0;
      busy <= 1'b0;
      sfr_rdata_o <= 8'h00;
      irq_o <= 1'b0;
      bus_clock_pin_o <= 1'b0;
      bus_clock_pin_oe_o <= 1'b0;
      bus_data_pin_o <= 1'b0;
      bus_data_pin_oe_o <= 1'b0;
    end else begin
      state <= next_state;
      ctrl <= next_ctrl;
      status <= next_status;
      data <= next_data;
      own_addr <= next_own_addr;
      cnt <= next_cnt;
      bitcnt <= next_bitcnt;
      master <= next_master;
      rx <= next_rx;
      addr_ph <= next_addr_ph;
      rep <= next_rep;
      busy <= next_busy;
      sfr_rdata_o <= next_rdata;
      irq_o <= next_irq;
      bus_clock_pin_o <= 1'b0;
      bus_clock_pin_oe_o <= scl_drv;
      bus_data_pin_o <= 1'b0;
      bus_data_pin_oe_o <= sda_drv;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_rx_ack_slot;
    state == s_ack_lo && rx && !addr_ph && ctrl[ACK_BIT];
  endsequence

  a_off_release: assert property (!en |=> !bus_clock_pin_oe_o && !bus_data_pin_oe_o)
    else $error("bus pins driven while interface off");
  a_halt_forced: assert property (!ctrl[ENABLE_BIT] |=> !ctrl[HALT_BIT])
    else $error("halt not forced low while disabled");
  a_irq_gate: assert property (1'b1 |=> irq_o == ($past(ctrl[EVENT_BIT]) && $past(bus_irq_enable_i)))
    else $error("interrupt not gated by flag and enable");
  a_start_code: assert property (state == s_start && tick && !rep && en |=> ctrl[EVENT_BIT] && status == ST_START)
    else $error("start did not post 08h");
  a_rstart_code: assert property (state == s_start && tick && rep && en |=> status == ST_RSTART)
    else $error("repeated start did not post 10h");
  a_stop_clear: assert property (stop_seen |=> !ctrl[HALT_BIT])
    else $error("halt not cleared after stop");
  a_event_sticky: assert property (ctrl[EVENT_BIT] && !ctrl_wr |=> ctrl[EVENT_BIT])
    else $error("event flag cleared without firmware");
  a_stretch_hold: assert property (state == s_hold |-> bus_clock_pin_oe_o)
    else $error("clock not held low during event");
  a_status_stable: assert property (en && ctrl[EVENT_BIT] && $past(ctrl[EVENT_BIT]) && $past(en) |-> $stable(status))
    else $error("status changed while event pending");
  a_rate_tick: assert property (tick && !ctrl_wr && ctrl[RATE_HI_BIT] == 1'b0 && ctrl[RATE_LO_MSB:0] == 2'b00 |=> cnt == 12'(DIV0 / 2 - 1))
    else $error("half period wrong for fastest rate");
  a_ack_drive: assert property (s_rx_ack_slot ##1 state == s_ack_lo |-> bus_data_pin_oe_o)
    else $error("receiver did not drive acknowledge");

endmodule

`default_nettype wire

// >>> sbus_pkg.sv
// package: register map, field positions, status codes and states
package sbus_pkg;
  // ---------------------------------------------------------------
  // register addresses and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'hd8;
  localparam logic [7:0] STAT_ADDR = 8'hd9;
  localparam logic [7:0] DATA_ADDR = 8'hda;
  localparam logic [7:0] OWN_ADDR = 8'hdb;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] OWN_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // control field positions
  localparam int RATE_HI_BIT = 7;
  localparam int ENABLE_BIT = 6;
  localparam int BEGIN_BIT = 5;
  localparam int HALT_BIT = 4;
  localparam int EVENT_BIT = 3;
  localparam int ACK_BIT = 2;
  localparam int RATE_LO_MSB = 1;
  localparam logic [1:0] LINK_SEL_BUS = 2'b10;
  // ---------------------------------------------------------------
  // status codes
  // ---------------------------------------------------------------
  localparam logic [7:0] ST_IDLE = 8'hf8;
  localparam logic [7:0] ST_START = 8'h08;
  localparam logic [7:0] ST_RSTART = 8'h10;
  localparam logic [7:0] ST_AW_ACK = 8'h18;
  localparam logic [7:0] ST_AW_NACK = 8'h20;
  localparam logic [7:0] ST_DW_ACK = 8'h28;
  localparam logic [7:0] ST_DW_NACK = 8'h30;
  localparam logic [7:0] ST_ARB_LOST = 8'h38;
  localparam logic [7:0] ST_AR_ACK = 8'h40;
  localparam logic [7:0] ST_AR_NACK = 8'h48;
  localparam logic [7:0] ST_DR_ACK = 8'h50;
  localparam logic [7:0] ST_DR_NACK = 8'h58;
  // ---------------------------------------------------------------
  // bit rate: cpu clock division factors, one bit per factor
  // ---------------------------------------------------------------
  localparam int DIV0 = 10;
  localparam int DIV1 = 20;
  localparam int DIV2 = 30;
  localparam int DIV3 = 40;
  localparam int DIV4 = 80;
  localparam int DIV5 = 120;
  localparam int DIV6 = 160;
  localparam int TIMER_BASE = 256;
  localparam int TIMER_MULT = 12;
  localparam int BITS_PER_BYTE = 8;
  // bus sequencer states
  typedef enum logic [3:0] {
    s_idle, s_wait, s_start, s_hold, s_bit_lo, s_bit_hi, s_ack_lo,
    s_ack_hi, s_rs_lo, s_rs_hi, s_stop_lo, s_stop_hi, s_stop_end
  } sbus_state_e;
endpackage

// >>> sbus_slave_model.sv
// behavioural two-wire slave that answers reads from an incrementing source
`timescale 1ns/1ps
`default_nettype none
module sbus_slave_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50,
  parameter logic [7:0] DATA_BASE = 8'h5a
) (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic slow_i,
  output logic scl_oe_o,
  output logic sda_oe_o
);
  logic [7:0] sh;
  logic [7:0] tx;
  logic [7:0] nxt;
  logic act;
  logic hit;
  logic rd;
  logic mack;
  int cnt;
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
    act = 1'b0;
    hit = 1'b0;
    rd = 1'b0;
    mack = 1'b0;
    nxt = DATA_BASE;
    cnt = 0;
  end
  // start and stop are data edges with the clock high
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    act = 1'b1;
    hit = 1'b0;
    cnt = 0;
  end
  always @(posedge sda_i) if (scl_i === 1'b1) begin
    act = 1'b0;
    sda_oe_o = 1'b0;
  end
  // sample on the rising clock, msb first; the ninth bit is the ack
  always @(posedge scl_i) if (act) begin
    if (cnt == 8) mack = !sda_i;
    else sh = {sh[6:0], sda_i};
    cnt++;
  end
  // the data line only moves while the clock is low
  always @(negedge scl_i) if (act) begin
    if (cnt == 8 && !hit) begin
      hit = (sh[7:1] == DEV_ADDR);
      rd = sh[0];
      mack = 1'b1;
      act = hit;
      sda_oe_o = hit;
    end else if (cnt == 8) begin
      sda_oe_o = !rd;
    end else if (cnt == 9) begin
      cnt = 0;
      sda_oe_o = 1'b0;
      if (rd && mack) begin
        tx = nxt;
        nxt++;
        sda_oe_o = !tx[7];
      end
      // a slow peripheral stretches the low clock before going on
      if (slow_i) begin
        scl_oe_o = 1'b1;
        #3000;
        scl_oe_o = 1'b0;
      end
    end else if (rd && hit) begin
      sda_oe_o = !tx[7-cnt];
    end
  end
endmodule
`default_nettype wire

// >>> serial_bus_master_receiver_ctrl_tb.sv
// testbench: register-level firmware sequences against a slave model
`timescale 1ns/1ps
`default_nettype none
module serial_bus_master_receiver_ctrl_tb;
  import sbus_pkg::*;
  localparam logic [7:0] EN = 8'h40;
  localparam logic [7:0] BG = 8'h20;
  localparam logic [7:0] HL = 8'h10;
  localparam logic [7:0] AK = 8'h04;
  logic clk, rst_n, wr_s, irq_en, irq, slow;
  logic c_o, c_oe, d_o, d_oe, m_scl_oe, m_sda_oe, scl_w, sda_w;
  logic [7:0] addr, wdata, rdata, reload, v, n, base;
  logic [1:0] sel;
  int fails, compares, cycles;
  int f[8];
  // open-drain wires: any enable pulls low, else the pull-up wins
  assign scl_w = !(c_oe | m_scl_oe);
  assign sda_w = !(d_oe | m_sda_oe);
  serial_bus_master_receiver_ctrl i_serial_bus_master_receiver_ctrl (
    .core_clk_i(clk), .rst_n_i(rst_n), .sfr_addr_i(addr), .sfr_wr_i(wr_s),
    .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .host_link_select_i(sel),
    .bus_irq_enable_i(irq_en), .timer_reload_i(reload), .irq_o(irq),
    .bus_clock_pin_i(scl_w), .bus_clock_pin_o(c_o),
    .bus_clock_pin_oe_o(c_oe), .bus_data_pin_i(sda_w),
    .bus_data_pin_o(d_o), .bus_data_pin_oe_o(d_oe));
  sbus_slave_model i_sbus_slave_model (.scl_i(scl_w), .sda_i(sda_w),
    .slow_i(slow), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));
  always #5 clk = ~clk;
  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // inputs move on the falling edge, a write strobe lasts one cycle
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
  endtask
  // read data is registered, so it is taken one cycle later
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    d = rdata;
  endtask
  // firmware polls the event flag, then checks the status code
  task automatic wait_ev(input logic [7:0] st);
    do reg_rd(CTRL_ADDR, v); while (v[EVENT_BIT] !== 1'b1);
    reg_rd(STAT_ADDR, v);
    chk(v, st);
  endtask
  task automatic wait_idle();
    do reg_rd(STAT_ADDR, v); while (v !== ST_IDLE);
  endtask
  // one clock period on the wire, measured between two rising edges
  task automatic meas(output logic [7:0] cyc);
    realtime t0;
    @(posedge scl_w);
    t0 = $realtime;
    @(posedge scl_w);
    cyc = 8'(int'(($realtime - t0) / 10.0));
  endtask
  task automatic wrap_up();
    $display("mismatches=%0d comparisons=%0d", fails, compares);
    if (fails == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // a hang is cut short and counted as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      wrap_up();
    end
  end
  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    clk = 0; rst_n = 0; wr_s = 0; addr = 8'h00; wdata = 8'h00;
    sel = 2'b01; irq_en = 0; reload = 8'hfe; slow = 0;
    fails = 0; compares = 0; cycles = 0;
    f = '{DIV0, DIV1, DIV2, DIV3, DIV4, DIV5, DIV6,
          (TIMER_BASE - 254) * TIMER_MULT};
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst_n = 1;
    reg_rd(CTRL_ADDR, v); chk(v, CTRL_RESET);
    reg_rd(STAT_ADDR, v); chk(v, ST_IDLE);
    reg_rd(DATA_ADDR, v); chk(v, DATA_RESET);
    reg_rd(OWN_ADDR, v); chk(v, OWN_RESET);
    reg_wr(OWN_ADDR, 8'h5c);
    reg_rd(OWN_ADDR, v);
    chk(v, 8'h5c);
    reg_rd(8'hc0, v); chk(v, UNMAPPED_READ);
    reg_wr(STAT_ADDR, 8'h55);
    reg_rd(STAT_ADDR, v); chk(v, ST_IDLE);
    // disabled: halt is forced low, the other bits keep their values
    reg_wr(CTRL_ADDR, 8'h97);
    reg_rd(CTRL_ADDR, v); chk(v, 8'h87);
    // enabled but the link select is wrong: nothing goes on the bus
    reg_wr(CTRL_ADDR, EN | BG);
    repeat (300) @(negedge clk);
    reg_rd(STAT_ADDR, v); chk(v, ST_IDLE);
    chk({6'h00, c_oe, d_oe}, 8'h00);
    chk({6'h00, c_o, d_o}, 8'h00);
    reg_wr(CTRL_ADDR, 8'h00);
    sel = LINK_SEL_BUS;
    // every rate code, each with an address that no slave answers
    for (int c = 0; c < 8; c++) begin
      base = {c[2], 5'h00, c[1:0]};
      reg_wr(CTRL_ADDR, base | EN | BG);
      wait_ev(ST_START);
      reg_wr(DATA_ADDR, {7'h33, 1'b1});
      reg_wr(CTRL_ADDR, base | EN);
      meas(n);
      chk(n, 8'(f[c]));
      wait_ev(ST_AR_NACK);
      reg_wr(CTRL_ADDR, base | EN | HL);
      wait_idle();
    end
    // two-byte read from a stretching slave, last byte not acknowledged
    slow = 1;
    irq_en = 1;
    reg_wr(CTRL_ADDR, EN | AK | BG);
    wait_ev(ST_START);
    chk({7'h00, irq}, 8'h01);
    chk({7'h00, c_oe}, 8'h01);
    irq_en = 0;
    repeat (2) @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    reg_wr(DATA_ADDR, {7'h50, 1'b1});
    reg_wr(CTRL_ADDR, EN | AK);
    wait_ev(ST_AR_ACK);
    chk(i_sbus_slave_model.sh, 8'ha1);
    reg_wr(CTRL_ADDR, EN | AK);
    wait_ev(ST_DR_ACK);
    reg_rd(DATA_ADDR, v); chk(v, 8'h5a);
    chk({7'h00, i_sbus_slave_model.mack}, 8'h01);
    reg_wr(CTRL_ADDR, EN);
    wait_ev(ST_DR_NACK);
    reg_rd(DATA_ADDR, v); chk(v, 8'h5b);
    chk({7'h00, i_sbus_slave_model.mack}, 8'h00);
    reg_wr(CTRL_ADDR, EN | HL);
    wait_idle();
    reg_rd(CTRL_ADDR, v); chk(v, EN);
    // repeated start, switch to write, then stop followed by start
    slow = 0;
    reg_wr(CTRL_ADDR, EN | BG);
    wait_ev(ST_START);
    reg_wr(DATA_ADDR, {7'h33, 1'b1});
    reg_wr(CTRL_ADDR, EN);
    wait_ev(ST_AR_NACK);
    reg_wr(CTRL_ADDR, EN | BG);
    wait_ev(ST_RSTART);
    reg_wr(DATA_ADDR, {7'h50, 1'b0});
    reg_wr(CTRL_ADDR, EN);
    wait_ev(ST_AW_ACK);
    reg_wr(CTRL_ADDR, EN | BG | HL);
    wait_ev(ST_START);
    reg_rd(CTRL_ADDR, v); chk({7'h00, v[HALT_BIT]}, 8'h00);
    reg_wr(CTRL_ADDR, EN | HL);
    wait_idle();
    // halt while not master only acts internally
    reg_wr(CTRL_ADDR, EN | HL);
    repeat (20) @(negedge clk);
    reg_rd(CTRL_ADDR, v); chk(v, EN);
    reg_rd(STAT_ADDR, v); chk(v, ST_IDLE);
    wrap_up();
  end
endmodule
`default_nettype wire
